// ---- rtl/cmg_pkg.sv ----
// Constants for the comparator mask gating block.
// Function
// - Level select picks which comparator polarity blocks.
// - Bit 13 feeds true source C to OR.
// - Bit 12 feeds inverted source C to OR.
// - Bit 11 feeds true source B to OR.
// - Bit 10 feeds inverted source B to OR.
// - Bits 9 and 8 feed source A to OR.
// - Bits 7 and 6 feed AND output to OR.
// - Bits 5 and 4 feed source C to AND.
package cmg_pkg;
    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [11:0] CTRL_ADDR  = 12'h000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hBFFF;  // Bit 14 reads zero.
    localparam int LVL_BIT   = 15;
    localparam int ORC_T_BIT = 13;
    localparam int ORC_N_BIT = 12;
    localparam int ORB_T_BIT = 11;
    localparam int ORB_N_BIT = 10;
    localparam int ORA_T_BIT = 9;
    localparam int ORA_N_BIT = 8;
    localparam int ANDN_BIT  = 7;
    localparam int ANDP_BIT  = 6;
    localparam int ANC_T_BIT = 5;
    localparam int ANC_N_BIT = 4;
    localparam int ANB_T_BIT = 3;
    localparam int ANB_N_BIT = 2;
    localparam int ANA_T_BIT = 1;
    localparam int ANA_N_BIT = 0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : cmg_pkg

// ---- rtl/cmg_mask_gating.sv ----
// Comparator mask gating logic with an AHB-Lite control register.
`timescale 1ns/1ps
module cmg_mask_gating (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparator_in,
    input  wire logic        mask_source_a,
    input  wire logic        mask_source_b,
    input  wire logic        mask_source_c,
    output logic             comparator_out,
    output logic             blank_active
);
    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic        wr_pend_q;
    logic        and_gate_output;
    logic        or_out;

    // Zero wait states: every transfer completes in its data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Capture a write address phase; data lands one cycle later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= hsel && hwrite && htrans == cmg_pkg::HTRANS_NONSEQ
                         && haddr == cmg_pkg::CTRL_ADDR;
        end
    end

    // Control register; unmapped addresses write nothing and read zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= cmg_pkg::CTRL_RESET;
        end else if (wr_pend_q) begin
            ctrl_q <= hwdata[15:0] & cmg_pkg::CTRL_WMASK;
        end
    end

    // Read data is registered during the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && !hwrite
                     && htrans == cmg_pkg::HTRANS_NONSEQ
                     && haddr == cmg_pkg::CTRL_ADDR) begin
            hrdata <= {16'h0000, ctrl_q};
        end else begin
            hrdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Gating network
    // ------------------------------------------------------------------
    // An enabled true and inverted pair gives a constant one on that leg.
    function automatic logic term(input logic src, input logic en_t,
                                  input logic en_n);
        term = (en_t & src) | (en_n & ~src);
    endfunction : term

    // AND gate with no input enabled is taken as low, so it blanks only through the inverted AND leg (bit 7).
    always_comb begin
        and_gate_output = ctrl_q[cmg_pkg::ANC_T_BIT]
                        | ctrl_q[cmg_pkg::ANC_N_BIT]
                        | ctrl_q[cmg_pkg::ANB_T_BIT]
                        | ctrl_q[cmg_pkg::ANB_N_BIT]
                        | ctrl_q[cmg_pkg::ANA_T_BIT]
                        | ctrl_q[cmg_pkg::ANA_N_BIT];
        // Each enabled leg must be true for the AND to be true.
        if (ctrl_q[cmg_pkg::ANC_T_BIT] | ctrl_q[cmg_pkg::ANC_N_BIT])
            and_gate_output &= term(mask_source_c,
                ctrl_q[cmg_pkg::ANC_T_BIT], ctrl_q[cmg_pkg::ANC_N_BIT]);
        if (ctrl_q[cmg_pkg::ANB_T_BIT] | ctrl_q[cmg_pkg::ANB_N_BIT])
            and_gate_output &= term(mask_source_b,
                ctrl_q[cmg_pkg::ANB_T_BIT], ctrl_q[cmg_pkg::ANB_N_BIT]);
        if (ctrl_q[cmg_pkg::ANA_T_BIT] | ctrl_q[cmg_pkg::ANA_N_BIT])
            and_gate_output &= term(mask_source_a,
                ctrl_q[cmg_pkg::ANA_T_BIT], ctrl_q[cmg_pkg::ANA_N_BIT]);
    end

    // OR gate collects every enabled leg.
    always_comb begin
        or_out = term(mask_source_c, ctrl_q[cmg_pkg::ORC_T_BIT],
                      ctrl_q[cmg_pkg::ORC_N_BIT])
               | term(mask_source_b, ctrl_q[cmg_pkg::ORB_T_BIT],
                      ctrl_q[cmg_pkg::ORB_N_BIT])
               | term(mask_source_a, ctrl_q[cmg_pkg::ORA_T_BIT],
                      ctrl_q[cmg_pkg::ORA_N_BIT])
               | term(and_gate_output, ctrl_q[cmg_pkg::ANDP_BIT],
                      ctrl_q[cmg_pkg::ANDN_BIT]);
    end

    // Output stage is registered, adding one cycle of latency.
    // Blanking holds the output at the comparator's idle level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comparator_out <= 1'b0;
            blank_active   <= 1'b0;
        end else begin
            blank_active <= or_out;
            if (or_out && (comparator_in == ~ctrl_q[cmg_pkg::LVL_BIT]))
                comparator_out <= ctrl_q[cmg_pkg::LVL_BIT];
            else
                comparator_out <= comparator_in;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // A blanked cycle must leave the output at the level-select value one
    // clock later; an unblanked cycle must copy the comparator.
    chk_blank_high_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (or_out && !ctrl_q[cmg_pkg::LVL_BIT]) |=> !comparator_out)
        else $error("high comparator level passed while blanked");

    chk_blank_low_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (or_out && ctrl_q[cmg_pkg::LVL_BIT]) |=> comparator_out)
        else $error("low comparator level passed while blanked");

    chk_pass_through: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !or_out |=> comparator_out == $past(comparator_in))
        else $error("comparator not passed when unblanked");

    // Every enabled source leg of the OR that is true must raise the blanking flag.
    chk_or_src_c: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORC_T_BIT] && mask_source_c) |=> blank_active)
        else $error("source c did not blank");

    chk_or_src_c_inv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORC_N_BIT] && !mask_source_c) |=> blank_active)
        else $error("inverted source c did not blank");

    chk_or_src_b: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORB_T_BIT] && mask_source_b) |=> blank_active)
        else $error("source b did not blank");

    chk_or_src_b_inv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORB_N_BIT] && !mask_source_b) |=> blank_active)
        else $error("inverted source b did not blank");

    chk_or_src_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORA_T_BIT] && mask_source_a) |=> blank_active)
        else $error("source a did not blank");

    chk_or_src_a_inv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORA_N_BIT] && !mask_source_a) |=> blank_active)
        else $error("inverted source a did not blank");

    // The AND-true checks only hold when the B and A legs are switched off,
    // because any of those legs being false would pull the AND low.
    logic and_ab_off;
    assign and_ab_off =
        ctrl_q[cmg_pkg::ANB_T_BIT:cmg_pkg::ANA_N_BIT] == 4'h0;

    chk_and_true: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ANDP_BIT] && ctrl_q[cmg_pkg::ANC_T_BIT]
         && mask_source_c && and_ab_off) |=> blank_active)
        else $error("and output did not blank");

    chk_and_src_c_inv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ANDP_BIT] && ctrl_q[cmg_pkg::ANC_N_BIT]
         && !mask_source_c && and_ab_off) |=> blank_active)
        else $error("inverted source c did not pass the and gate");

    chk_and_out_inv: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ANDN_BIT] && ctrl_q[cmg_pkg::ANC_T_BIT]
         && !ctrl_q[cmg_pkg::ANC_N_BIT] && !mask_source_c
         && and_ab_off) |=> blank_active)
        else $error("inverted and output did not blank");

    chk_and_leg_blocks: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[cmg_pkg::ORC_T_BIT:cmg_pkg::ANDN_BIT] == 7'h00
         && ctrl_q[cmg_pkg::ANDP_BIT] && ctrl_q[cmg_pkg::ANC_T_BIT]
         && !ctrl_q[cmg_pkg::ANC_N_BIT] && !mask_source_c)
        |=> !blank_active)
        else $error("false and leg still blanked");

    chk_no_enable: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (ctrl_q[15:4] & cmg_pkg::CTRL_WMASK[15:4] & 12'h7FF) == 12'h000
        |=> !blank_active)
        else $error("blank without any enable");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    // Main scenarios: both blanking polarities, a write and the AND path.
    cov_blanked: cover property (@(posedge hclk) disable iff (!hresetn)
        or_out && comparator_in);
    cov_low_level: cover property (@(posedge hclk) disable iff (!hresetn)
        or_out && ctrl_q[cmg_pkg::LVL_BIT] && !comparator_in);
    cov_write: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_q);
    cov_and_gate: cover property (@(posedge hclk) disable iff (!hresetn)
        and_gate_output && ctrl_q[cmg_pkg::ANDP_BIT]);
endmodule : cmg_mask_gating

// ---- verif/cmg_src_model.sv ----
// Partner model: comparator and mask source levels seen by the block.
`timescale 1ns/1ps
module cmg_src_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] pattern,
    output logic            comparator_in,
    output logic            mask_source_a,
    output logic            mask_source_b,
    output logic            mask_source_c
);
    logic [3:0] lvl_q;
    // Levels launch on the clock, as the PWM logic does, so no glitch.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= pattern;
        end
    end
    assign {comparator_in, mask_source_c} = lvl_q[3:2];
    assign {mask_source_b, mask_source_a} = lvl_q[1:0];
endmodule : cmg_src_model

// ---- verif/test_comparator_mask_gating.sv ----
// Self-checking bench for the comparator mask gating block.
`timescale 1ns/1ps
module test_comparator_mask_gating;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        cmp_in, src_a, src_b, src_c, cmp_out, blank;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0]  pattern;
    int          mismatches, checks_done;

    cmg_mask_gating dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .comparator_in(cmp_in),
        .mask_source_a(src_a), .mask_source_b(src_b),
        .mask_source_c(src_c), .comparator_out(cmp_out),
        .blank_active(blank));
    cmg_src_model src (.hclk(hclk), .hresetn(hresetn), .pattern(pattern),
        .comparator_in(cmp_in), .mask_source_a(src_a),
        .mask_source_b(src_b), .mask_source_c(src_c));

    // ------------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task chk32(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk32
    task chk1(input string n, input logic e, input logic s);
        chk32(n, {31'h0, e}, {31'h0, s});
    endtask : chk1
    // Waits for hready at a rising edge; a stuck slave ends the run.
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            final_report();
        end
    endtask : wait_ready
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= cmg_pkg::HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus
    // Expected {comparator_out, blank_active} for a setting and levels.
    function automatic logic [1:0] exp_gate(logic [15:0] c, logic [3:0] p);
        logic [2:0] s, at, an;
        logic       andg, orv;
        s = p[2:0];
        at = {c[5], c[3], c[1]};
        an = {c[4], c[2], c[0]};
        andg = (|(at | an)) & (&((at & s) | (an & ~s) | ~(at | an)));
        orv = |(({c[13], c[11], c[9]} & s) | ({c[12], c[10], c[8]} & ~s));
        orv = orv | (c[7] & ~andg) | (c[6] & andg);
        return {orv ? c[15] : p[3], orv};
    endfunction : exp_gate
    task gate_run(input logic [15:0] c);
        logic [1:0] e;
        bus(1'b1, 12'h000, {16'h0000, c});
        for (int p = 0; p < 16; p++) begin
            @(posedge hclk);
            pattern <= p[3:0];
            repeat (3) @(posedge hclk);
            #1;
            e = exp_gate(c, p[3:0]);
            chk1("blank_active", e[0], blank);
            chk1("comparator_out", e[1], cmp_out);
        end
    endtask : gate_run

    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, pattern} = '0;
        mismatches = 0;
        checks_done = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 12'h000, 32'h0);
        chk32("reset value", 32'h0, rd);
        bus(1'b1, 12'h000, 32'hFFFFFFFF);
        bus(1'b0, 12'h000, 32'h0);
        chk32("bit 14 reads zero", 32'h0000BFFF, rd);
        bus(1'b1, 12'h004, 32'h00001234);
        bus(1'b0, 12'h004, 32'h0);
        chk32("unmapped read", 32'h0, rd);
        bus(1'b0, 12'h000, 32'h0);
        chk32("unmapped write ignored", 32'h0000BFFF, rd);
        chk1("hresp", 1'b0, hresp);
        chk1("hreadyout", 1'b1, hreadyout);
        gate_run(16'h0000);
        gate_run(16'h2000);
        gate_run(16'h9000);
        gate_run(16'h0800);
        gate_run(16'h8400);
        gate_run(16'h0200);
        gate_run(16'h8100);
        gate_run(16'h0078);
        gate_run(16'h80A0);
        gate_run(16'h0056);
        gate_run(16'h0060);
        gate_run(16'h0050);
        // A reset in mid-run must clear the register and both outputs.
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk1("reset comparator_out", 1'b0, cmp_out);
        chk1("reset blank_active", 1'b0, blank);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 12'h000, 32'h0);
        chk32("register after mid-run reset", 32'h0, rd);
        final_report();
    end
endmodule : test_comparator_mask_gating
